/* File: src/adc_control_config.sv */
// Register file, sequencing and approximation control of the converter
// Function
// - configuration bit 7 selects low power
// - configuration bits 6:5 divide the input clock
// - configuration bit 4 selects long sample
// - configuration bits 3:2, value 10 gives ten bits
// - configuration bits 1:0 pick clock source, 00 bus
// - activity flag reads set while converting
// - trigger select, compare enable and compare sense bits
// - unimplemented trigger register bits read zero
// - completion flag bit 7 set on finish
// - bit 6 enables completion interrupt
// - bit 5 selects continuous, else one conversion
// - bits 4:0 select input channel
// - high byte read locks result until low read
// - compare value pair holds the threshold
// - pin bits disable digital I/O, conversions still allowed
// - full scale and zero codes at references
// - sample lasts 3.5 or 23.5 conversion clocks
// - compare gates completion flag and result store
// - interrupt raised when flag set and enabled
`timescale 1ns/1ps
module adc_control_config (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic alt_clock,
  input wire logic hw_trigger,
  input wire logic compare_high,
  output logic sample_hold,
  output logic [9:0] trial_code,
  output logic [4:0] channel_select,
  output logic low_power_select,
  output logic conversion_irq,
  output logic [15:0] pin_disable
);
  import adc_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Everything the block remembers, registered as one word
  typedef struct packed {
    conv_state_type st;
    logic [7:0] cfg;
    logic [7:0] trig;
    logic [7:0] chan;
    logic [7:0] cmp_hi;
    logic [7:0] cmp_lo;
    logic [7:0] pin1;
    logic [7:0] pin2;
    logic conversion_complete_flag;
    logic lock;
    logic [9:0] result;
    logic [9:0] sar;
    logic [3:0] bit_idx;
    logic [5:0] half_cnt;
    logic [1:0] settle;
    logic [2:0] cmp_sync;
    logic [2:0] trg_sync;
    logic trg_level;
    logic hold;
    logic [31:0] rdata;
    logic waitreq;
    logic irq;
  } state_type;

  state_type s_r;
  state_type s_nxt;
  logic half_tick;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Map a byte address to a register index, unmapped gives none
  // Offsets are word aligned; anything else reads zero
  function automatic logic [3:0] reg_index(input logic [5:0] addr);
    logic [3:0] idx;
    idx = IDX_NONE;
    case (addr)
      OFS_CONFIG: idx = IDX_CONFIG;
      OFS_TRIG: idx = IDX_TRIG;
      OFS_CHAN: idx = IDX_CHAN;
      OFS_RES_HI: idx = IDX_RES_HI;
      OFS_RES_LO: idx = IDX_RES_LO;
      OFS_CMP_HI: idx = IDX_CMP_HI;
      OFS_CMP_LO: idx = IDX_CMP_LO;
      OFS_PIN1: idx = IDX_PIN1;
      OFS_PIN2: idx = IDX_PIN2;
      default: idx = IDX_NONE;
    endcase
    return idx;
  endfunction

  // ----------------------------------------------------------------
  // Conversion clock
  // ----------------------------------------------------------------
  // Half-period ticks from the selected and divided source
  conv_clock_gen clock_gen (
    .clk_sys(clk_sys),
    .rst(rst),
    .input_clock_select(s_r.cfg[CFG_CLK_LSB +: 2]),
    .clock_divide_select(s_r.cfg[CFG_DIV_LSB +: 2]),
    .alt_clock(alt_clock),
    .half_tick(half_tick)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Bus access, then trigger, then the conversion sequence
  always_comb begin
    logic take;
    logic [3:0] idx;
    logic [7:0] wd;
    logic ten;
    logic [3:0] top_idx;
    logic [5:0] sample_len;
    logic start;
    logic abort;
    logic trg_rise;
    logic [9:0] cv;
    logic [9:0] mask;
    logic hit;
    s_nxt = s_r;
    take = (read | write) & s_r.waitreq;
    idx = reg_index(address);
    wd = writedata[7:0];
    // only encoding 10 converts ten bits
    ten = (s_r.cfg[CFG_MODE_LSB +: 2] == MODE_TEN_BIT);
    // Other modes convert eight bits with the low compare byte only
    top_idx = ten ? 4'h9 : 4'h7;
    mask = ten ? 10'h3FF : 10'h0FF;
    // 7 or 47 half periods of the conversion clock
    sample_len = s_r.cfg[CFG_LONG_SAMPLE_BIT] ? SAMPLE_LONG_HALF : SAMPLE_SHORT_HALF;
    start = 1'b0;
    abort = 1'b0;
    trg_rise = 1'b0;
    cv = ten ? {s_r.cmp_hi[1:0], s_r.cmp_lo} : {2'h0, s_r.cmp_lo};
    hit = 1'b0;

    // Input synchronisers, a change counts when the last two agree
    // The comparator comes from the analog core and is treated as a pin
    s_nxt.cmp_sync = {s_r.cmp_sync[1:0], compare_high};
    s_nxt.trg_sync = {s_r.trg_sync[1:0], hw_trigger};
    if (s_r.trg_sync[1] == s_r.trg_sync[2]) begin
      s_nxt.trg_level = s_r.trg_sync[2];
      trg_rise = s_r.trg_sync[2] & ~s_r.trg_level;
    end

    // Bus slave: answer one cycle after the request is taken
    // The answer cycle itself never takes, so a held request is not
    // executed twice; side effects land at the take edge
    s_nxt.waitreq = 1'b1;
    if (take) begin
      s_nxt.waitreq = 1'b0;
      s_nxt.rdata = 32'h0000_0000;
      if (read) begin
        case (idx)
          IDX_CONFIG: s_nxt.rdata[7:0] = s_r.cfg;
          // activity flag from the sequencer state
          IDX_TRIG: s_nxt.rdata[7:0] = {s_r.st != ST_IDLE, s_r.trig[6:4], 4'h0};
          IDX_CHAN: s_nxt.rdata[7:0] = {s_r.conversion_complete_flag, s_r.chan[6:0]};
          IDX_RES_HI: begin
            s_nxt.rdata[7:0] = {6'h00, s_r.result[9:8]};
            // high byte read locks the pair
            s_nxt.lock = 1'b1;
          end
          IDX_RES_LO: begin
            s_nxt.rdata[7:0] = s_r.result[7:0];
            // low byte read clears flag and lock
            s_nxt.lock = 1'b0;
            s_nxt.conversion_complete_flag = 1'b0;
          end
          IDX_CMP_HI: s_nxt.rdata[7:0] = {6'h00, s_r.cmp_hi[1:0]};
          IDX_CMP_LO: s_nxt.rdata[7:0] = s_r.cmp_lo;
          IDX_PIN1: s_nxt.rdata[7:0] = s_r.pin1;
          IDX_PIN2: s_nxt.rdata[7:0] = s_r.pin2;
          default: s_nxt.rdata = 32'h0000_0000;
        endcase
      end else if (byteenable[0]) begin
        // Writes use the low byte lane only
        case (idx)
          IDX_CONFIG: s_nxt.cfg = wd;
          // trigger, compare enable and sense bits kept
          IDX_TRIG: s_nxt.trig = {1'b0, wd[6:4], 4'h0};
          IDX_CHAN: begin
            s_nxt.chan = {1'b0, wd[6:0]};
            // abort, clear flag, restart on software trigger
            abort = 1'b1;
            s_nxt.conversion_complete_flag = 1'b0;
            // A held pair stays locked until its low byte is read
            start = ~s_r.trig[TRIG_SELECT_BIT];
          end
          IDX_CMP_HI: s_nxt.cmp_hi = {6'h00, wd[1:0]};
          IDX_CMP_LO: s_nxt.cmp_lo = wd;
          IDX_PIN1: s_nxt.pin1 = wd;
          IDX_PIN2: s_nxt.pin2 = wd;
          default: ;
        endcase
      end
    end

    // hardware trigger starts a conversion from idle
    // A pin edge while busy is dropped, not queued
    if (s_r.trig[TRIG_SELECT_BIT] && trg_rise && s_r.st == ST_IDLE) begin
      start = 1'b1;
    end

    // Conversion sequence
    case (s_r.st)
      // Idle waits for a software write or a pin edge
      ST_IDLE: ;
      ST_SAMPLE: begin
        // Count half periods of the conversion clock
        if (half_tick) begin
          s_nxt.half_cnt = 6'(s_r.half_cnt + 6'h01);
          if (6'(s_r.half_cnt + 6'h01) == sample_len) begin
            s_nxt.st = ST_CONVERT;
            s_nxt.bit_idx = top_idx;
            s_nxt.sar = 10'h000;
            s_nxt.sar[top_idx] = 1'b1;
            s_nxt.half_cnt = 6'h00;
            s_nxt.settle = 2'h0;
          end
        end
      end
      ST_CONVERT: begin
        // The comparator answer reaches the last sync stage three cycles
        // after the trial code moves; the settle count covers that
        if (s_r.settle != SETTLE_CYC) begin
          s_nxt.settle = 2'(s_r.settle + 2'h1);
        end
        if (half_tick && s_r.half_cnt < 6'h02) begin
          s_nxt.half_cnt = 6'(s_r.half_cnt + 6'h01);
        end
        // One trial per conversion clock, after the comparator settles
        if (s_r.half_cnt == 6'h02 && s_r.settle == SETTLE_CYC && s_r.cmp_sync[1] == s_r.cmp_sync[2]) begin
          // all ones at or above top, zero at or below bottom
          s_nxt.sar[s_r.bit_idx] = s_r.cmp_sync[2];
          s_nxt.half_cnt = 6'h00;
          s_nxt.settle = 2'h0;
          if (s_r.bit_idx == 4'h0) begin
            s_nxt.st = ST_FINISH;
          end else begin
            s_nxt.bit_idx = 4'(s_r.bit_idx - 4'h1);
            s_nxt.sar[4'(s_r.bit_idx - 4'h1)] = 1'b1;
          end
        end
      end
      ST_FINISH: begin
        // Compare result stored as code minus threshold, cut to width
        // compare decides whether the flag is set
        if (!s_r.trig[TRIG_CMP_EN_BIT]) begin
          hit = 1'b1;
        end else if (s_r.trig[TRIG_CMP_GT_BIT]) begin
          hit = (s_r.sar >= cv);
        end else begin
          hit = (s_r.sar < cv);
        end
        // a locked pair is not overwritten
        if (hit && !s_nxt.lock) begin
          s_nxt.result = s_r.trig[TRIG_CMP_EN_BIT] ? (10'(s_r.sar - cv) & mask) : s_r.sar;
          // set wins over a clear in the same cycle
          s_nxt.conversion_complete_flag = 1'b1;
        end
        // continuous restarts sampling, else stop
        // Continuous mode samples again without a new trigger
        if (s_r.chan[CHAN_CONT_BIT]) begin
          s_nxt.st = ST_SAMPLE;
          s_nxt.half_cnt = 6'h00;
        end else begin
          s_nxt.st = ST_IDLE;
        end
      end
      default: s_nxt.st = ST_IDLE;
    endcase

    // any channel may convert, pin bits only gate digital I/O
    // Abort comes before start, so a restart on the same write wins
    if (abort) begin
      s_nxt.st = ST_IDLE;
      s_nxt.sar = 10'h000;
    end
    if (start) begin
      s_nxt.st = ST_SAMPLE;
      s_nxt.half_cnt = 6'h00;
    end
    // Hold the input while the next state samples
    s_nxt.hold = (s_nxt.st == ST_SAMPLE);
    // interrupt follows flag and enable
    // Registered from the next flag, so it rises in the same cycle as the flag
    s_nxt.irq = s_nxt.conversion_complete_flag & s_nxt.chan[CHAN_IEN_BIT];
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // All state in one register, constants on reset
  // Sequencer idles and every register starts at its reset value
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_r <= '0;
      s_r.st <= ST_IDLE;
      s_r.cfg <= RST_CONFIG;
      s_r.trig <= RST_TRIG;
      s_r.chan <= RST_CHAN;
      s_r.cmp_hi <= RST_CMP;
      s_r.cmp_lo <= RST_CMP;
      s_r.pin1 <= RST_PIN;
      s_r.pin2 <= RST_PIN;
      // Bus answer idles high so nothing is taken in reset
      s_r.waitreq <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output is a field of the state register
  // so none of them glitches on a decode
  assign readdata = s_r.rdata;
  assign waitrequest = s_r.waitreq;
  assign sample_hold = s_r.hold;
  assign trial_code = s_r.sar;
  assign channel_select = s_r.chan[CHAN_SEL_LSB +: 5];
  // low power level to the analog core
  assign low_power_select = s_r.cfg[CFG_LOW_POWER_BIT];
  assign conversion_irq = s_r.irq;
  // pin disable bits to the pin logic
  assign pin_disable = {s_r.pin2, s_r.pin1};

endmodule

/* File: src/adc_ctrl_pkg.sv */
// Shared constants and types of the converter control block
package adc_ctrl_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets on the register bus
  // ----------------------------------------------------------------
  localparam logic [5:0] OFS_CONFIG = 6'h00;
  localparam logic [5:0] OFS_TRIG = 6'h04;
  localparam logic [5:0] OFS_CHAN = 6'h08;
  localparam logic [5:0] OFS_RES_HI = 6'h0C;
  localparam logic [5:0] OFS_RES_LO = 6'h10;
  localparam logic [5:0] OFS_CMP_HI = 6'h14;
  localparam logic [5:0] OFS_CMP_LO = 6'h18;
  localparam logic [5:0] OFS_PIN1 = 6'h1C;
  localparam logic [5:0] OFS_PIN2 = 6'h20;

  // Register indices after decode
  localparam logic [3:0] IDX_CONFIG = 4'h0;
  localparam logic [3:0] IDX_TRIG = 4'h1;
  localparam logic [3:0] IDX_CHAN = 4'h2;
  localparam logic [3:0] IDX_RES_HI = 4'h3;
  localparam logic [3:0] IDX_RES_LO = 4'h4;
  localparam logic [3:0] IDX_CMP_HI = 4'h5;
  localparam logic [3:0] IDX_CMP_LO = 4'h6;
  localparam logic [3:0] IDX_PIN1 = 4'h7;
  localparam logic [3:0] IDX_PIN2 = 4'h8;
  localparam logic [3:0] IDX_NONE = 4'hF;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFG_LOW_POWER_BIT = 7;
  localparam int CFG_DIV_LSB = 5;
  localparam int CFG_LONG_SAMPLE_BIT = 4;
  localparam int CFG_MODE_LSB = 2;
  localparam int CFG_CLK_LSB = 0;
  localparam int TRIG_ACTIVE_BIT = 7;
  localparam int TRIG_SELECT_BIT = 6;
  localparam int TRIG_CMP_EN_BIT = 5;
  localparam int TRIG_CMP_GT_BIT = 4;
  localparam int CHAN_CONVERSION_COMPLETE_FLAG_BIT = 7;
  localparam int CHAN_IEN_BIT = 6;
  localparam int CHAN_CONT_BIT = 5;
  localparam int CHAN_SEL_LSB = 0;

  // ----------------------------------------------------------------
  // Reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] RST_TRIG = 8'h00;
  localparam logic [7:0] RST_CHAN = 8'h00;
  localparam logic [7:0] RST_CMP = 8'h00;
  localparam logic [7:0] RST_PIN = 8'h00;
  localparam logic [1:0] MODE_TEN_BIT = 2'h2;
  localparam logic [1:0] CLK_BUS = 2'h0;
  localparam logic [1:0] CLK_BUS_HALF = 2'h1;
  localparam logic [1:0] CLK_ALT = 2'h2;
  localparam logic [1:0] CLK_ASYNC = 2'h3;

  // ----------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------
  // Sample lengths in half periods of the conversion clock (3.5 and 23.5)
  localparam logic [5:0] SAMPLE_SHORT_HALF = 6'h07;
  localparam logic [5:0] SAMPLE_LONG_HALF = 6'h2F;
  // Bus cycles a trial code stands before the comparator is read
  localparam logic [1:0] SETTLE_CYC = 2'h3;
  // Bus cycles per half period of the internal asynchronous source
  localparam logic [3:0] ASYNC_DIV = 4'h4;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_CONVERT,
    ST_FINISH
  } conv_state_type;

endpackage

/* File: src/conv_clock_gen.sv */
// Conversion clock source select and divider, giving half-period ticks
`timescale 1ns/1ps
module conv_clock_gen (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [1:0] input_clock_select,
  input wire logic [1:0] clock_divide_select,
  input wire logic alt_clock,
  output logic half_tick
);
  import adc_ctrl_pkg::*;

  typedef struct packed {
    logic [2:0] alt_sync;
    logic alt_level;
    logic pre;
    logic [3:0] async_cnt;
    logic [2:0] div_cnt;
    logic tick;
  } gen_state_type;

  gen_state_type s_r;
  gen_state_type s_nxt;
  logic base;
  logic [2:0] limit;

  // ----------------------------------------------------------------
  // Source select and divide
  // ----------------------------------------------------------------
  // Next state of the source prescalers and the divider
  always_comb begin
    s_nxt = s_r;
    s_nxt.alt_sync = {s_r.alt_sync[1:0], alt_clock};
    s_nxt.pre = ~s_r.pre;
    s_nxt.async_cnt = (s_r.async_cnt == ASYNC_DIV - 4'h1) ? 4'h0 : 4'(s_r.async_cnt + 4'h1);
    base = 1'b0;
    // Alternate clock counts once the last two stages agree
    if (s_r.alt_sync[1] == s_r.alt_sync[2]) begin
      s_nxt.alt_level = s_r.alt_sync[2];
    end
    case (input_clock_select)
      CLK_BUS: base = 1'b1;
      CLK_BUS_HALF: base = s_r.pre;
      CLK_ALT: base = (s_r.alt_sync[1] == s_r.alt_sync[2]) && (s_r.alt_sync[2] != s_r.alt_level);
      CLK_ASYNC: base = (s_r.async_cnt == ASYNC_DIV - 4'h1);
      default: base = 1'b1;
    endcase
    // divide by 1, 2, 4 or 8
    case (clock_divide_select)
      2'h0: limit = 3'h0;
      2'h1: limit = 3'h1;
      2'h2: limit = 3'h3;
      default: limit = 3'h7;
    endcase
    s_nxt.tick = 1'b0;
    if (base) begin
      if (s_r.div_cnt >= limit) begin
        s_nxt.div_cnt = 3'h0;
        s_nxt.tick = 1'b1;
      end else begin
        s_nxt.div_cnt = 3'(s_r.div_cnt + 3'h1);
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign half_tick = s_r.tick;

endmodule

/* File: test/adc_control_config_chk.sv */
// Port assertions for the converter control block
`timescale 1ns/1ps
module adc_control_config_chk
  import adc_ctrl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic sample_hold,
  input wire logic [4:0] channel_select,
  input wire logic low_power_select,
  input wire logic conversion_irq,
  input wire logic [15:0] pin_disable
);
  logic take;
  logic wtake;
  logic trig_sel_r;
  logic ien_r;

  assign take = (read || write) && waitrequest;
  assign wtake = take && write && byteenable[0];

  // Shadow of trigger select and interrupt enable
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      trig_sel_r <= 1'b0;
      ien_r <= 1'b0;
    end else if (wtake) begin
      if (address == OFS_TRIG) trig_sel_r <= writedata[TRIG_SELECT_BIT];
      if (address == OFS_CHAN) ien_r <= writedata[CHAN_IEN_BIT];
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_answer; take |=> !waitrequest ##1 waitrequest; endproperty
  a_answer: assert property (p_answer) else $error("bus answer not one cycle");
  property p_power; wtake && address == OFS_CONFIG |-> ##2 low_power_select == $past(writedata[7], 2); endproperty
  a_power: assert property (p_power) else $error("low power select wrong");
  property p_chan; wtake && address == OFS_CHAN |-> ##2 channel_select == $past(writedata[4:0], 2); endproperty
  a_chan: assert property (p_chan) else $error("channel select wrong");
  property p_pin; wtake && address == OFS_PIN1 |-> ##2 pin_disable[7:0] == $past(writedata[7:0], 2); endproperty
  a_pin: assert property (p_pin) else $error("pin disable wrong");
  property p_unimpl; !waitrequest && $past(read) && $past(address) == OFS_TRIG |-> readdata[3:0] == 4'h0; endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented bits not zero");
  property p_start; wtake && address == OFS_CHAN && !trig_sel_r |=> sample_hold; endproperty
  a_start: assert property (p_start) else $error("software start missing");
  property p_irq; $rose(conversion_irq) |-> ien_r; endproperty
  a_irq: assert property (p_irq) else $error("interrupt while disabled");
  property p_irq_off; wtake && address == OFS_CHAN && !writedata[6] |-> ##2 !conversion_irq; endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt not masked");
endmodule

bind adc_control_config adc_control_config_chk u_chk (.clk_sys(clk_sys), .rst(rst), .address(address),
  .read(read), .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .sample_hold(sample_hold), .channel_select(channel_select),
  .low_power_select(low_power_select), .conversion_irq(conversion_irq), .pin_disable(pin_disable));

/* File: test/sar_core_model.sv */
// Sample-and-hold and comparator model of the analog core
`timescale 1ns/1ps
module sar_core_model (
  input wire logic clk_sys,
  input wire logic sample_hold,
  input wire logic [9:0] trial_code,
  input wire integer level,
  output logic compare_high
);
  int held = 0;

  always @(posedge clk_sys) begin
    if (sample_hold === 1'b1) held <= level;
  end

  assign compare_high = (held >= int'(trial_code));
endmodule

/* File: test/adc_control_config_bench.sv */
// Self-checking bench of the converter control block
`timescale 1ns/1ps
module adc_control_config_bench;
  import adc_ctrl_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [5:0] address = 6'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hF;
  logic alt_clock = 1'b0;
  logic hw_trigger = 1'b0;
  logic [31:0] lfsr_r = 32'haa37;
  logic [31:0] q;
  wire logic [31:0] readdata;
  wire logic waitrequest, sample_hold, compare_high, low_power_select, conversion_irq;
  wire logic [9:0] trial_code;
  wire logic [4:0] channel_select;
  wire logic [15:0] pin_disable;
  int level = 0;
  int sh_cnt = 0;
  int cycles = 0;
  int miscompares = 0;
  int n_tests = 0;
  int a;
  int cfgs[6] = '{8'h08, 8'h18, 8'h98, 8'h6B, 8'h09, 8'h0A};
  int lvls[6] = '{300, 2000, 0, 512, 1, 1023};
  int shs[6] = '{7, 47, 47, -1, -1, -1};

  adc_control_config u_dut (.clk_sys(clk_sys), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .alt_clock(alt_clock), .hw_trigger(hw_trigger), .compare_high(compare_high), .sample_hold(sample_hold),
    .trial_code(trial_code), .channel_select(channel_select), .low_power_select(low_power_select),
    .conversion_irq(conversion_irq), .pin_disable(pin_disable));
  sar_core_model u_core (.clk_sys(clk_sys), .sample_hold(sample_hold), .trial_code(trial_code),
    .level(level), .compare_high(compare_high));

  always #20 clk_sys = ~clk_sys;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Random alternate clock, sample length count, hang guard
  always @(posedge clk_sys) begin
    lfsr_r <= lfsr(lfsr_r);
    alt_clock <= lfsr_r[3];
    if (sample_hold === 1'b1) sh_cnt <= sh_cnt + 1;
    cycles <= cycles + 1;
    if (cycles > 30000) begin
      miscompares++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (miscompares == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Avalon access held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [5:0] ad, input logic [7:0] d);
    @(posedge clk_sys);
    address <= ad;
    write <= wr;
    read <= !wr;
    writedata <= {24'h0, d};
    @(posedge clk_sys);
    while (waitrequest !== 1'b0) @(posedge clk_sys);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] ad, input logic [7:0] d);
    bus(1'b1, ad, d);
  endtask

  task automatic rd(input logic [5:0] ad, input logic [31:0] e);
    bus(1'b0, ad, 8'h00);
    chk(q, e);
  endtask

  // Start on channel 1, optionally by the pin, then await or refuse the flag
  task automatic conv(input int lvl, input bit hw, input bit flag);
    int n;
    n = 0;
    level = lvl;
    sh_cnt = 0;
    wr(OFS_CHAN, 8'h41);
    if (hw) begin
      repeat (20) @(negedge clk_sys);
      chk(sh_cnt, 0);
      @(posedge clk_sys);
      hw_trigger <= 1'b1;
      repeat (8) @(posedge clk_sys);
      hw_trigger <= 1'b0;
    end
    if (flag) begin
      while (conversion_irq !== 1'b1 && n < 3000) begin
        @(negedge clk_sys);
        n++;
      end
      chk(conversion_irq, 1'b1);
    end else begin
      repeat (600) @(negedge clk_sys);
      chk(conversion_irq, 1'b0);
    end
  endtask

  task automatic res(input int v);
    rd(OFS_RES_HI, (v >> 8) & 3);
    rd(OFS_RES_LO, v & 255);
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++) rd(6'(i * 4), 0);
    wr(OFS_CONFIG, 8'h98);
    byteenable <= 4'h0;
    wr(OFS_CONFIG, 8'h00);
    byteenable <= 4'hF;
    rd(OFS_CONFIG, 8'h98);
    chk(low_power_select, 1'b1);
    wr(OFS_PIN1, 8'h02);
    a = int'(lfsr_r[7:0]);
    wr(OFS_PIN2, 8'(a));
    chk(pin_disable, {8'(a), 8'h02});
    wr(OFS_TRIG, 8'h7C);
    rd(OFS_TRIG, 8'h70);
    for (int i = 0; i < 6; i++) begin
      wr(OFS_CONFIG, cfgs[i][7:0]);
      wr(OFS_TRIG, 8'h00);
      conv(lvls[i], 0, 1);
      if (shs[i] >= 0) chk(sh_cnt, shs[i]);
      res(lvls[i] > 1023 ? 1023 : lvls[i]);
      rd(OFS_CHAN, 8'h41);
      chk(conversion_irq, 1'b0);
      chk(channel_select, 5'h01);
    end
    a = int'(lfsr_r[8:0]) + 1;
    wr(OFS_CONFIG, 8'h08);
    conv(a, 0, 1);
    rd(OFS_RES_HI, (a >> 8) & 3);
    wr(OFS_CHAN, 8'h41);
    repeat (300) @(negedge clk_sys);
    chk(conversion_irq, 1'b0);
    rd(OFS_RES_LO, a & 255);
    wr(OFS_CMP_HI, 8'((a + 1) >> 8));
    wr(OFS_CMP_LO, 8'(a + 1));
    wr(OFS_TRIG, 8'h30);
    conv(a, 0, 0);
    wr(OFS_TRIG, 8'h20);
    conv(a, 0, 1);
    res(1023);
    wr(OFS_CMP_HI, 8'((a / 2) >> 8));
    wr(OFS_CMP_LO, 8'(a / 2));
    wr(OFS_TRIG, 8'h30);
    conv(a, 0, 1);
    res(a - a / 2);
    wr(OFS_TRIG, 8'h40);
    conv(a, 1, 1);
    res(a);
    wr(OFS_TRIG, 8'h00);
    wr(OFS_CHAN, 8'h01);
    rd(OFS_TRIG, 8'h80);
    repeat (300) @(negedge clk_sys);
    chk(conversion_irq, 1'b0);
    rd(OFS_CHAN, 8'h81);
    rd(OFS_TRIG, 8'h00);
    res(a);
    stop_test();
  end
endmodule
